// ===== motor_speed_pkg.sv
// Purpose: Shared constants and types for the speed-command front end.
// Assumes: 200 MHz core clock; register port with 8-bit byte address.
// Notes: Fractions are 13-bit, with 13'h1000 standing for 100 percent.
// Function
// RQ1: Turn a gate on only after the opposite gate sensed off.
// RQ2: Open loop maps command to target duty, clamped at minimum floor.
// RQ3: Speed loop scales command by full-scale speed, floor-clamped.
// RQ4: Power loop scales command by full-scale power, floor-clamped.
// RQ5: Command below stop threshold zeroes setpoint and stops the motor.
// RQ6: Applied duty settles at target or loop output; ramp shapes transients.
// RQ7: Analog source gives zero command at or below standby entry.
// RQ8: Analog command rises linearly above exit level, clamps at 100 percent.
// RQ9: PWM source measures input duty; zero at entry, linear above exit.
// RQ10: Input PWM range is selectable, independent of output switching.
// RQ11: Host sets sleep delay longer than input PWM low time.
// RQ12: Serial source uses the host-written serial speed register directly.
// RQ13: Serial mode sleeps when pin low after serial zero past delay.
// RQ14: Serial mode wakes when pin exceeds sleep exit level.
// RQ15: Serial mode stays standby for small serial speed with pin high.
// RQ16: Frequency source counts input edges; zero at entry, linear above.
// RQ17: Frequency command reaches and clamps at 100 percent at maximum.
// RQ18: Sleep or standby while setpoint zero; start once it is nonzero.
// RQ19: Linear mapping is fixed-point, saturating, updated every window.
// RQ20: Hysteresis between entry and exit keeps previous run decision.
package motor_speed_pkg;
  localparam int CLK_MHZ = 200;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SB_ENTRY = 8'h04;
  localparam logic [7:0] OFS_SB_EXIT = 8'h08;
  localparam logic [7:0] OFS_GAIN = 8'h0c;
  localparam logic [7:0] OFS_STOP_THR = 8'h10;
  localparam logic [7:0] OFS_MIN_DUTY = 8'h14;
  localparam logic [7:0] OFS_MAX_SPEED = 8'h18;
  localparam logic [7:0] OFS_MAX_POWER = 8'h1c;
  localparam logic [7:0] OFS_SERIAL_SPEED = 8'h20;
  localparam logic [7:0] OFS_SLEEP_TIME = 8'h24;
  localparam logic [7:0] OFS_SLEEP_LEVELS = 8'h28;
  localparam logic [7:0] OFS_RAMP_STEP = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_SETPOINT = 8'h34;
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_LOOP_LSB = 2;
  localparam int CTRL_RANGE_LSB = 4;
  localparam int CTRL_SURGE_BIT = 6;
  localparam int LEVEL_EXIT_LSB = 16;
  localparam int STATE_LSB = 16;
  localparam int FRAC_SHIFT = 12;
  localparam logic [12:0] DUTY_FULL = 13'h1000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] SB_ENTRY_RST = 16'h0080;
  localparam logic [15:0] SB_EXIT_RST = 16'h0100;
  localparam logic [15:0] GAIN_RST = 16'h1000;
  localparam logic [12:0] STOP_THR_RST = 13'h0040;
  localparam logic [12:0] MIN_DUTY_RST = 13'h0100;
  localparam logic [15:0] MAX_SPEED_RST = 16'h0fa0;
  localparam logic [15:0] MAX_POWER_RST = 16'h0064;
  localparam logic [31:0] SLEEP_TIME_RST = 32'h0001_0000;
  localparam logic [11:0] SLEEP_ENTRY_RST = 12'h020;
  localparam logic [11:0] SLEEP_EXIT_RST = 12'h040;
  localparam logic [12:0] RAMP_STEP_RST = 13'h0010;
  localparam logic [19:0] PWM_WIN_CYC = 20'h01000;
  localparam int FREQ_GATE_US = 1000;
  localparam int FREQ_GATE_CYC = FREQ_GATE_US * CLK_MHZ;
  typedef enum logic [1:0] {
    SRC_ANALOG = 2'b00, SRC_PWM = 2'b01, SRC_SERIAL = 2'b10, SRC_FREQ = 2'b11
  } source_e;
  typedef enum logic [1:0] {
    LOOP_OPEN = 2'b00, LOOP_SPEED = 2'b01, LOOP_POWER = 2'b10,
    LOOP_RSVD = 2'b11
  } loop_e;
  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00, ST_STANDBY = 2'b01, ST_RUN = 2'b10
  } motor_state_e;
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } gate_s;
endpackage

// ===== motor_speed_command_mux.sv
// Purpose: Speed source mux, command mapping, setpoint, state, gate interlock.
// Assumes: Inputs synchronous to I_MCLK; speed pin level digitised by an ADC.
// Notes: Software supplies the linear gain so no divider is needed.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module motor_speed_command_mux #(
  parameter int FREQ_WIN_CYC = motor_speed_pkg::FREQ_GATE_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WR_DATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RD_DATA,
  input wire logic [11:0] I_SPEED_LEVEL,
  input wire logic I_SPEED_PIN,
  input wire logic [12:0] I_LOOP_DUTY,
  input wire motor_speed_pkg::gate_s I_GATE_REQ,
  input wire motor_speed_pkg::gate_s I_VGS_OFF,
  output motor_speed_pkg::gate_s O_GATE,
  output logic [12:0] O_DUTY_CMD,
  output logic [15:0] O_SETPOINT,
  output logic [12:0] O_DUTY_OUT,
  output motor_speed_pkg::motor_state_e O_STATE
);
  import motor_speed_pkg::*;

  logic [31:0] ctrl_reg;
  logic [15:0] sb_entry_reg, sb_exit_reg, gain_reg;
  logic [12:0] stop_thr_reg, min_duty_reg, ramp_step_reg, serial_reg;
  logic [15:0] max_speed_reg, max_power_reg;
  logic [31:0] sleep_time_reg;
  logic [11:0] sleep_entry_reg, sleep_exit_reg;
  logic [31:0] rd_reg;
  source_e src;
  loop_e loop_mode;
  logic [1:0] range;
  logic [19:0] win_cnt_reg, high_cnt_reg, win_len;
  logic [15:0] edge_cnt_reg, meas_reg;
  logic pin_prev_reg;
  logic running_reg, running_next;
  logic [15:0] x_in;
  logic [12:0] cmd_reg, cmd_next;
  logic [15:0] setpoint_reg, setpoint_next;
  logic [12:0] duty_out_reg, duty_goal;
  logic [31:0] sleep_cnt_reg;
  logic zero_input, sleep_go, wake;
  motor_state_e state_reg, state_next;
  gate_s gate_reg, gate_next;

  assign src = source_e'(ctrl_reg[CTRL_SRC_LSB +: 2]);
  assign loop_mode = loop_e'(ctrl_reg[CTRL_LOOP_LSB +: 2]);
  assign range = ctrl_reg[CTRL_RANGE_LSB +: 2];

  // Saturating fixed-point line: zero at base, full scale clamp on top
  function automatic logic [12:0] lin_map(input logic [15:0] x,
      input logic [15:0] base, input logic [15:0] gain);
    logic [31:0] p;
    p = 32'h0;
    if (x <= base) begin
      return 13'h0;
    end
    p = {16'h0, x - base} * {16'h0, gain};
    if (p[31:FRAC_SHIFT] >= {7'h0, DUTY_FULL}) begin
      return DUTY_FULL;
    end
    return p[FRAC_SHIFT +: 13];
  endfunction

  // Scales a fraction of full command by a full-scale quantity
  function automatic logic [15:0] scale(input logic [12:0] frac,
      input logic [15:0] full);
    logic [31:0] p;
    p = {19'h0, frac} * {16'h0, full};
    return p[FRAC_SHIFT +: 16];
  endfunction

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_reg <= CTRL_RST;
      sb_entry_reg <= SB_ENTRY_RST;
      sb_exit_reg <= SB_EXIT_RST;
      gain_reg <= GAIN_RST;
      stop_thr_reg <= STOP_THR_RST;
      min_duty_reg <= MIN_DUTY_RST;
      max_speed_reg <= MAX_SPEED_RST;
      max_power_reg <= MAX_POWER_RST;
      serial_reg <= 13'h0;
      sleep_time_reg <= SLEEP_TIME_RST;
      sleep_entry_reg <= SLEEP_ENTRY_RST;
      sleep_exit_reg <= SLEEP_EXIT_RST;
      ramp_step_reg <= RAMP_STEP_RST;
    end else if (I_WR) begin
      unique case (I_ADDR)
        OFS_CTRL: ctrl_reg <= {25'h0, I_WR_DATA[6:0]};
        OFS_SB_ENTRY: sb_entry_reg <= I_WR_DATA[15:0];
        OFS_SB_EXIT: sb_exit_reg <= I_WR_DATA[15:0];
        OFS_GAIN: gain_reg <= I_WR_DATA[15:0];
        OFS_STOP_THR: stop_thr_reg <= I_WR_DATA[12:0];
        OFS_MIN_DUTY: min_duty_reg <= I_WR_DATA[12:0];
        OFS_MAX_SPEED: max_speed_reg <= I_WR_DATA[15:0];
        OFS_MAX_POWER: max_power_reg <= I_WR_DATA[15:0];
        // RQ12 host serial speed
        OFS_SERIAL_SPEED: serial_reg <= I_WR_DATA[12:0];
        OFS_SLEEP_TIME: sleep_time_reg <= I_WR_DATA;
        OFS_SLEEP_LEVELS: begin
          sleep_entry_reg <= I_WR_DATA[11:0];
          sleep_exit_reg <= I_WR_DATA[LEVEL_EXIT_LSB +: 12];
        end
        OFS_RAMP_STEP: ramp_step_reg <= I_WR_DATA[12:0];
        default: ;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rd_reg <= 32'h0;
    end else if (!I_RD) begin
      rd_reg <= 32'h0;
    end else begin
      unique case (I_ADDR)
        OFS_CTRL: rd_reg <= ctrl_reg;
        OFS_SB_ENTRY: rd_reg <= {16'h0, sb_entry_reg};
        OFS_SB_EXIT: rd_reg <= {16'h0, sb_exit_reg};
        OFS_GAIN: rd_reg <= {16'h0, gain_reg};
        OFS_STOP_THR: rd_reg <= {19'h0, stop_thr_reg};
        OFS_MIN_DUTY: rd_reg <= {19'h0, min_duty_reg};
        OFS_MAX_SPEED: rd_reg <= {16'h0, max_speed_reg};
        OFS_MAX_POWER: rd_reg <= {16'h0, max_power_reg};
        OFS_SERIAL_SPEED: rd_reg <= {19'h0, serial_reg};
        OFS_SLEEP_TIME: rd_reg <= sleep_time_reg;
        OFS_SLEEP_LEVELS:
          rd_reg <= {4'h0, sleep_exit_reg, 4'h0, sleep_entry_reg};
        OFS_RAMP_STEP: rd_reg <= {19'h0, ramp_step_reg};
        OFS_STATUS: rd_reg <= {14'h0, state_reg, 3'h0, cmd_reg};
        OFS_SETPOINT: rd_reg <= {16'h0, setpoint_reg};
        default: rd_reg <= 32'h0;
      endcase
    end
  end

  // RQ10 range selects window
  // Longer windows accept slower input waves at the cost of update rate
  always_comb begin
    if (src == SRC_FREQ) begin
      win_len = 20'(FREQ_WIN_CYC) << range;
    end else begin
      win_len = PWM_WIN_CYC << range;
    end
  end

  // RQ9 duty and RQ16 frequency measured over one window
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      win_cnt_reg <= 20'h0;
      high_cnt_reg <= 20'h0;
      edge_cnt_reg <= 16'h0;
      meas_reg <= 16'h0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= I_SPEED_PIN;
      if (win_cnt_reg >= win_len - 20'h1) begin
        win_cnt_reg <= 20'h0;
        high_cnt_reg <= 20'h0;
        edge_cnt_reg <= 16'h0;
        // Closing sample counts too, so a steady high pin reads full scale
        if (src == SRC_FREQ) begin
          meas_reg <= edge_cnt_reg + {15'h0, I_SPEED_PIN & ~pin_prev_reg};
        end else begin
          meas_reg <= 16'((high_cnt_reg + {19'h0, I_SPEED_PIN}) >> range);
        end
      end else begin
        win_cnt_reg <= win_cnt_reg + 20'h1;
        high_cnt_reg <= high_cnt_reg + {19'h0, I_SPEED_PIN};
        edge_cnt_reg <= edge_cnt_reg + {15'h0, I_SPEED_PIN & ~pin_prev_reg};
      end
    end
  end

  always_comb begin
    unique case (src)
      SRC_ANALOG: x_in = {4'h0, I_SPEED_LEVEL};
      SRC_SERIAL: x_in = {3'h0, serial_reg};
      SRC_PWM, SRC_FREQ: x_in = meas_reg;
    endcase
  end

  // RQ20 entry exit hysteresis
  always_comb begin
    running_next = running_reg;
    if (x_in <= sb_entry_reg) begin
      running_next = 1'b0;
    end else if (x_in >= sb_exit_reg) begin
      running_next = 1'b1;
    end
  end

  // RQ7 RQ8 RQ17 mapping
  always_comb begin
    cmd_next = 13'h0;
    if (src == SRC_SERIAL) begin
      // RQ15 serial standby band
      cmd_next = (x_in <= sb_entry_reg) ? 13'h0 : serial_reg;
    end else if (running_next) begin
      // RQ19 saturating fixed point
      cmd_next = lin_map(x_in, sb_exit_reg, gain_reg);
    end
    // RQ14 serial speed only after wake
    if (src == SRC_SERIAL && state_reg == ST_SLEEP && !wake) begin
      cmd_next = 13'h0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      running_reg <= 1'b0;
      cmd_reg <= 13'h0;
    end else begin
      running_reg <= running_next;
      cmd_reg <= cmd_next;
    end
  end

  // RQ5 stop threshold, RQ2 RQ3 RQ4 floor clamp and scaling
  always_comb begin
    logic [12:0] frac;
    frac = (cmd_reg <= min_duty_reg) ? min_duty_reg : cmd_reg;
    unique case (loop_mode)
      LOOP_SPEED: setpoint_next = scale(frac, max_speed_reg);
      LOOP_POWER: setpoint_next = scale(frac, max_power_reg);
      default: setpoint_next = {3'h0, frac};
    endcase
    if (cmd_reg < stop_thr_reg) begin
      setpoint_next = 16'h0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      setpoint_reg <= 16'h0;
    end else begin
      setpoint_reg <= setpoint_next;
    end
  end

  // RQ13 sleep delay timer
  assign zero_input = (src == SRC_SERIAL) ? (serial_reg == 13'h0)
                                          : (cmd_reg == 13'h0);
  assign sleep_go = (sleep_cnt_reg > sleep_time_reg) &&
      (src != SRC_SERIAL || I_SPEED_LEVEL < sleep_entry_reg);
  assign wake = I_SPEED_LEVEL > sleep_exit_reg;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sleep_cnt_reg <= 32'h0;
    end else if (!zero_input) begin
      sleep_cnt_reg <= 32'h0;
    end else if (sleep_cnt_reg != 32'hffff_ffff) begin
      sleep_cnt_reg <= sleep_cnt_reg + 32'h1;
    end
  end

  // RQ18 state follows setpoint
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (setpoint_reg == 16'h0) state_next = ST_STANDBY;
      end
      ST_STANDBY: begin
        if (setpoint_reg != 16'h0) state_next = ST_RUN;
        else if (sleep_go) state_next = ST_SLEEP;
      end
      ST_SLEEP: begin
        // RQ14 serial wake level
        if (src == SRC_SERIAL) begin
          if (wake) state_next = ST_STANDBY;
        end else if (setpoint_reg != 16'h0) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_STANDBY;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= ST_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  // RQ6 duty ramps toward its steady goal
  // Surge guard limits falls too, so braking energy cannot pump the bus
  assign duty_goal = (state_reg != ST_RUN) ? 13'h0 :
      (loop_mode == LOOP_OPEN) ? setpoint_reg[12:0] : I_LOOP_DUTY;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      duty_out_reg <= 13'h0;
    end else if (duty_goal > duty_out_reg) begin
      if (ramp_step_reg == 13'h0 || duty_goal - duty_out_reg <= ramp_step_reg)
        duty_out_reg <= duty_goal;
      else
        duty_out_reg <= duty_out_reg + ramp_step_reg;
    end else if (duty_goal < duty_out_reg) begin
      if (!ctrl_reg[CTRL_SURGE_BIT] || ramp_step_reg == 13'h0 ||
          duty_out_reg - duty_goal <= ramp_step_reg)
        duty_out_reg <= duty_goal;
      else
        duty_out_reg <= duty_out_reg - ramp_step_reg;
    end
  end

  // RQ1 gate interlock
  always_comb begin
    gate_next.hs = I_GATE_REQ.hs & ~I_GATE_REQ.ls & ~gate_reg.ls & I_VGS_OFF.ls;
    gate_next.ls = I_GATE_REQ.ls & ~I_GATE_REQ.hs & ~gate_reg.hs & I_VGS_OFF.hs;
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gate_reg <= '0;
    end else begin
      gate_reg <= gate_next;
    end
  end

  assign O_RD_DATA = rd_reg;
  assign O_DUTY_CMD = cmd_reg;
  assign O_SETPOINT = setpoint_reg;
  assign O_DUTY_OUT = duty_out_reg;
  assign O_STATE = state_reg;
  assign O_GATE = gate_reg;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  a_hs_after_ls: assert property ( // RQ1
    ((gate_reg.hs & ~$past(gate_reg.hs)) &
     ($past(gate_reg.ls) | ~$past(I_VGS_OFF.ls))) == 3'h0)
    else $error("high side on before low side off");
  a_ls_after_hs: assert property ( // RQ1
    ((gate_reg.ls & ~$past(gate_reg.ls)) &
     ($past(gate_reg.hs) | ~$past(I_VGS_OFF.hs))) == 3'h0)
    else $error("low side on before high side off");
  a_stop_zero: assert property ( // RQ5
    (cmd_reg < stop_thr_reg) |=> (setpoint_reg == 16'h0))
    else $error("setpoint not zero below stop threshold");
  a_open_floor: assert property ( // RQ2
    (loop_mode == LOOP_OPEN && cmd_reg >= stop_thr_reg &&
     cmd_reg <= min_duty_reg) |=> (setpoint_reg == {3'h0, $past(min_duty_reg)}))
    else $error("open loop floor clamp lost");
  a_speed_full: assert property ( // RQ3
    (loop_mode == LOOP_SPEED && cmd_reg == DUTY_FULL &&
     stop_thr_reg <= DUTY_FULL) |=> (setpoint_reg == $past(max_speed_reg)))
    else $error("full command not full speed");
  a_power_full: assert property ( // RQ4
    (loop_mode == LOOP_POWER && cmd_reg == DUTY_FULL &&
     stop_thr_reg <= DUTY_FULL) |=> (setpoint_reg == $past(max_power_reg)))
    else $error("full command not full power");
  a_entry_zero: assert property ( // RQ7
    (src != SRC_SERIAL && x_in <= sb_entry_reg) |=> (cmd_reg == 13'h0))
    else $error("command not zero at standby entry");
  a_cmd_sat: assert property ( // RQ19
    cmd_reg <= DUTY_FULL)
    else $error("command above full scale");
  a_run_start: assert property ( // RQ18
    (state_reg == ST_STANDBY && setpoint_reg != 16'h0) |=> (state_reg == ST_RUN))
    else $error("no start with nonzero setpoint");
  a_run_stop: assert property ( // RQ18
    (state_reg == ST_RUN && setpoint_reg == 16'h0) |=> (state_reg == ST_STANDBY))
    else $error("run kept with zero setpoint");
  a_serial_wake: assert property ( // RQ14
    (src == SRC_SERIAL && state_reg == ST_SLEEP && wake) |=>
      (state_reg == ST_STANDBY))
    else $error("serial mode did not wake");
  a_duty_settle: assert property ( // RQ6
    (duty_goal == duty_out_reg) [*2] |=> (duty_out_reg == $past(duty_goal)))
    else $error("applied duty left its steady goal");

  c_run: cover property (state_reg == ST_STANDBY ##1 state_reg == ST_RUN);
  c_sleep: cover property (state_reg == ST_STANDBY ##1 state_reg == ST_SLEEP);
  c_full: cover property (cmd_reg == DUTY_FULL);
  c_gate: cover property ($rose(gate_reg.hs[0]));
endmodule

// ===== speed_host_model.sv
// Purpose: Host-side stand-in: speed pin waveform and gate VGS sensing.
// Assumes: Shares the block clock; wave set by period and high count.
// Notes: Period 0 parks the pin low, as its pull-down would.
`timescale 1ns/1ps
module speed_host_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_period,
  input wire logic [15:0] i_high,
  input wire motor_speed_pkg::gate_s i_gate,
  output logic o_speed_pin,
  output motor_speed_pkg::gate_s o_vgs_off
);
  import motor_speed_pkg::*;
  logic [15:0] phase_reg;
  logic [5:0] low1_reg;
  logic [5:0] low2_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_reg <= 16'h0000;
    end else if (i_period == 16'h0000 || phase_reg >= i_period - 16'h0001) begin
      phase_reg <= 16'h0000;
    end else begin
      phase_reg <= phase_reg + 16'h0001;
    end
  end

  assign o_speed_pin = (i_period != 16'h0000) && (phase_reg < i_high);

  // slow gate discharge
  // Sense reports off two cycles after drive drops, so a lazy interlock shows
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low1_reg <= 6'h3f;
      low2_reg <= 6'h3f;
    end else begin
      low1_reg <= ~i_gate;
      low2_reg <= low1_reg;
    end
  end

  assign o_vgs_off = low1_reg & low2_reg & ~i_gate;
endmodule

// ===== test_motor_speed_command_mux.sv
// Purpose: Self-checking bench for the speed-command front end.
// Assumes: Host model drives the speed pin and VGS sense lines.
// Notes: Frequency window shortened to 256 cycles; ramp step full early in the analog test, then 0x100.
`timescale 1ns/1ps
module test_motor_speed_command_mux;
  import motor_speed_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rd_data;
  logic [11:0] level = 12'h000;
  logic pin;
  logic [12:0] loop_duty = 13'h0;
  gate_s gate_req = 6'b0;
  gate_s vgs_off;
  gate_s gate;
  logic [12:0] duty_cmd;
  logic [15:0] setpoint;
  logic [12:0] duty_out;
  motor_state_e state;
  logic [15:0] period = 16'h0;
  logic [15:0] high = 16'h0;
  int mismatches = 0;
  int cmp_count = 0;

  always #2.5 mclk = ~mclk;

  motor_speed_command_mux #(.FREQ_WIN_CYC(256)) DUT (.I_MCLK(mclk),
    .I_RST_N(rst_n), .I_ADDR(addr), .I_WR_DATA(wr_data), .I_WR(wr),
    .I_RD(rd), .O_RD_DATA(rd_data), .I_SPEED_LEVEL(level),
    .I_SPEED_PIN(pin), .I_LOOP_DUTY(loop_duty), .I_GATE_REQ(gate_req),
    .I_VGS_OFF(vgs_off), .O_GATE(gate), .O_DUTY_CMD(duty_cmd),
    .O_SETPOINT(setpoint), .O_DUTY_OUT(duty_out), .O_STATE(state));

  speed_host_model host (.i_clk(mclk), .i_rst_n(rst_n), .i_period(period),
    .i_high(high), .i_gate(gate), .o_speed_pin(pin), .o_vgs_off(vgs_off));

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: output got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk_reg(rd_data, e);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Level change, then pipeline of three registers plus a full ramp step
  task automatic set_level(input logic [11:0] v);
    @(posedge mclk);
    level <= v;
    wait_cyc(8);
  endtask

  task automatic t_regs;
    logic [7:0] ra[12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
      8'h18, 8'h1c, 8'h24, 8'h28, 8'h2c, 8'h3c};
    logic [31:0] rv[12] = '{32'h0, 32'h80, 32'h100, 32'h1000, 32'h40,
      32'h100, 32'hfa0, 32'h64, 32'h10000, 32'h0040_0020, 32'h10, 32'h0};
    for (int i = 0; i < 12; i++) begin
      rd_chk(ra[i], rv[i]);
    end
    chk_out(16'(state), 16'(ST_STANDBY));
    wr_reg(OFS_STATUS, 32'hffff_ffff);
    wr_reg(8'h3c, 32'hffff_ffff);
    rd_chk(OFS_STATUS, 32'h0001_0000);
    rd_chk(8'h3c, 32'h0);
  endtask

  task automatic t_analog;
    wr_reg(OFS_RAMP_STEP, 32'h1000);
    set_level(12'h080);
    chk_out(16'(duty_cmd), 16'h0);
    chk_out(setpoint, 16'h0);
    set_level(12'h300);
    chk_out(16'(duty_cmd), 16'h200);
    chk_out(setpoint, 16'h200);
    chk_out(16'(state), 16'(ST_RUN));
    chk_out(16'(duty_out), 16'h200);
    rd_chk(OFS_STATUS, 32'h0002_0200);
    set_level(12'h180);
    chk_out(setpoint, 16'h100);
    set_level(12'h120);
    chk_out(setpoint, 16'h0);
    chk_out(16'(state), 16'(ST_STANDBY));
    wr_reg(OFS_GAIN, 32'h2000);
    set_level(12'hfff);
    chk_out(16'(duty_cmd), 16'h1000);
    wr_reg(OFS_RAMP_STEP, 32'h100);
    wr_reg(OFS_CTRL, 32'h40);
    set_level(12'h300);
    chk_out(16'(duty_out), 16'ha00);
    wait_cyc(8);
    chk_out(16'(duty_out), 16'h400);
  endtask

  task automatic t_loops;
    logic [15:0] full[2] = '{16'h0fa0, 16'h0064};
    @(posedge mclk);
    loop_duty <= 13'h345;
    for (int i = 0; i < 2; i++) begin
      wr_reg(OFS_CTRL, 32'(i + 1) << CTRL_LOOP_LSB);
      set_level(12'hfff);
      chk_out(setpoint, full[i]);
      chk_out(16'(duty_out), 16'h345);
      set_level(12'h300);
      chk_out(setpoint, full[i] >> 2);
      set_level(12'h140);
      chk_out(setpoint, full[i] >> 4);
    end
    wr_reg(OFS_GAIN, 32'h1000);
  endtask

  task automatic t_serial;
    wr_reg(OFS_CTRL, 32'h2);
    wr_reg(OFS_SLEEP_TIME, 32'h14);
    wr_reg(OFS_SERIAL_SPEED, 32'h800);
    wait_cyc(8);
    chk_out(16'(duty_cmd), 16'h800);
    chk_out(16'(state), 16'(ST_RUN));
    wr_reg(OFS_SERIAL_SPEED, 32'h60);
    wait_cyc(8);
    chk_out(16'(duty_cmd), 16'h0);
    chk_out(16'(state), 16'(ST_STANDBY));
    wr_reg(OFS_SERIAL_SPEED, 32'h0);
    wait_cyc(40);
    chk_out(16'(state), 16'(ST_STANDBY));
    set_level(12'h010);
    wait_cyc(40);
    chk_out(16'(state), 16'(ST_SLEEP));
    wr_reg(OFS_SERIAL_SPEED, 32'h800);
    wait_cyc(8);
    chk_out(16'(duty_cmd), 16'h0);
    set_level(12'h050);
    chk_out(16'(duty_cmd), 16'h800);
    chk_out(16'(state), 16'(ST_RUN));
  endtask

  task automatic t_pwm;
    wr_reg(OFS_SLEEP_TIME, 32'h10000);
    wr_reg(OFS_CTRL, 32'h1);
    @(posedge mclk);
    period <= 16'd64;
    high <= 16'd32;
    wait_cyc(2 * 4096 + 16);
    chk_out(16'(duty_cmd), 16'h700);
    wr_reg(OFS_CTRL, 32'h11);
    wait_cyc(2 * 8192 + 16);
    chk_out(16'(duty_cmd), 16'h700);
    wr_reg(OFS_CTRL, 32'h1);
    @(posedge mclk);
    high <= 16'd2;
    wait_cyc(2 * 4096 + 16);
    chk_out(16'(duty_cmd), 16'h0);
  endtask

  task automatic t_freq;
    wr_reg(OFS_CTRL, 32'h3);
    wr_reg(OFS_SB_ENTRY, 32'h2);
    wr_reg(OFS_SB_EXIT, 32'h4);
    wr_reg(OFS_GAIN, 32'h8000);
    @(posedge mclk);
    period <= 16'd4;
    high <= 16'd2;
    wait_cyc(2 * 256 + 16);
    chk_out(16'(duty_cmd), 16'h1e0);
    wr_reg(OFS_CTRL, 32'h33);
    @(posedge mclk);
    high <= 16'd1;
    period <= 16'd2;
    wait_cyc(2 * 2048 + 16);
    chk_out(16'(duty_cmd), 16'h1000);
    @(posedge mclk);
    period <= 16'd0;
    wait_cyc(2 * 2048 + 16);
    chk_out(16'(duty_cmd), 16'h0);
  endtask

  task automatic t_gate;
    @(posedge mclk);
    gate_req <= 6'b000_001;
    wait_cyc(8);
    chk_out(16'(gate), 16'h01);
    @(posedge mclk);
    gate_req <= 6'b011_010;
    wait_cyc(1);
    chk_out(16'(gate), 16'h00);
    wait_cyc(8);
    chk_out(16'(gate), 16'h08);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Budget well above the two longest measurement windows combined
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_analog();
    t_loops();
    t_serial();
    t_pwm();
    t_freq();
    t_gate();
    end_sim();
  end
endmodule
